//--- logic/iee_pkg.sv
// Package: constants and types of the interrupt entry and exit sequencer
package iee_pkg;
  // Vector, program counter and timing constants
  localparam int unsigned PC_WIDTH_DEF      = 12;
  localparam int unsigned NUM_SRC_DEF       = 8;
  localparam int unsigned ENTRY_CYCLES      = 4;
  localparam int unsigned JUMP_CYCLES       = 3;
  localparam int unsigned WAKE_EXTRA_CYCLES = 4;
  localparam int unsigned RETURN_CYCLES     = 4;
  localparam int unsigned PC_BYTES          = 2;
  localparam int unsigned GIE_BIT           = 7;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  localparam logic [15:0] SP_RESET          = 16'h009F;
  localparam logic [15:0] RESET_VECTOR      = 16'h0000;
  localparam logic [15:0] INSTR_WORD_BYTES  = 16'h0002;
  // APB register byte addresses
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_ENABLE  = 8'h04;
  localparam logic [7:0] ADDR_FLAG    = 8'h08;
  localparam logic [7:0] ADDR_LEVTYPE = 8'h0C;
  localparam logic [7:0] ADDR_SP      = 8'h10;
  localparam logic [7:0] ADDR_PC      = 8'h14;
  localparam logic [7:0] ADDR_STATE   = 8'h18;
  // Sequencer states
  typedef enum logic [2:0] {
    IEE_RUN,
    IEE_WAKE,
    IEE_ENTRY,
    IEE_RETURN
  } iee_state_t;
endpackage : iee_pkg

//--- logic/iee_core.sv
// Interrupt entry and exit sequencer for a small 8-bit core
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module iee_core
#(
  parameter int unsigned PC_WIDTH = iee_pkg::PC_WIDTH_DEF,
  parameter int unsigned NUM_SRC  = iee_pkg::NUM_SRC_DEF
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Interrupt sources
  input  wire logic [NUM_SRC-1:0]   src_event,
  input  wire logic [NUM_SRC-1:0]   src_level,
  output logic      [NUM_SRC-1:0]   src_ack,
  // Pipeline side
  input  wire logic                 instr_boundary,
  input  wire logic                 instr_two_word,
  input  wire logic                 ret_instr,
  input  wire logic                 clear_global_irq_enable_instr,
  input  wire logic                 set_global_irq_enable_instr,
  input  wire logic                 core_sleeping,
  output logic                      pipe_stall,
  output logic      [PC_WIDTH-1:0]  program_counter,
  output logic                      stack_we,
  output logic      [15:0]          stack_addr,
  output logic      [7:0]           stack_wdata,
  input  wire logic [7:0]           stack_rdata,
  output logic                      global_irq_enable
);
  import iee_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  iee_state_t               state_q;
  logic [2:0]               cnt_q;
  logic [7:0]               status_flag_register_q;
  logic [NUM_SRC-1:0]       enable_q;
  logic [NUM_SRC-1:0]       flag_q;
  logic [NUM_SRC-1:0]       levtype_q;
  logic [15:0]              sp_q;
  logic [PC_WIDTH-1:0]      pc_q;
  logic [PC_WIDTH-1:0]      ret_pc_q;
  logic [$clog2(NUM_SRC)-1:0] sel_q;
  logic                     hold_one_q;

  // Bus decode
  logic apb_wr;
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Request and arbitration
  logic [NUM_SRC-1:0]         pending;
  logic [NUM_SRC-1:0]         eligible;
  logic                       any_req;
  logic [$clog2(NUM_SRC)-1:0] winner;
  logic                       take;

  // Flag-type sources use the latch; level-type ones follow the live condition
  assign pending  = (flag_q & ~levtype_q) | (src_level & levtype_q);
  assign eligible = pending & enable_q;
  assign any_req  = |eligible;

  // Lowest index is the lowest vector and so the highest priority
  always_comb
  begin
    winner = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (eligible[i])
      begin
        winner = i[$clog2(NUM_SRC)-1:0];
      end
    end
  end

  // Taken only at a boundary, never in the cycle of a clear-enable, never
  // in the guard instruction after set-enable or after a return
  assign take = (state_q == IEE_RUN) && instr_boundary && any_req
             && status_flag_register_q[GIE_BIT]
             && !clear_global_irq_enable_instr
             && !hold_one_q;

  assign global_irq_enable = status_flag_register_q[GIE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, clocked straight from pclk with no divider in between
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= IEE_RUN;
      cnt_q   <= '0;
      sel_q   <= '0;
    end
    else
    begin
      unique case (state_q)
        IEE_RUN:
        begin
          if (take)
          begin
            sel_q   <= winner;
            cnt_q   <= '0;
            state_q <= core_sleeping ? IEE_WAKE : IEE_ENTRY;
          end
          else if (ret_instr && instr_boundary)
          begin
            cnt_q   <= '0;
            state_q <= IEE_RETURN;
          end
        end
        IEE_WAKE:
        begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q == 3'(WAKE_EXTRA_CYCLES - 1))
          begin
            cnt_q   <= '0;
            state_q <= IEE_ENTRY;
          end
        end
        IEE_ENTRY:
        begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q == 3'(ENTRY_CYCLES - 1))
          begin
            state_q <= IEE_RUN;
          end
        end
        IEE_RETURN:
        begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q == 3'(RETURN_CYCLES - 1))
          begin
            state_q <= IEE_RUN;
          end
        end
      endcase
    end
  end

  // Core is held while a sequence runs; one-cycle ALU ops need no stall
  assign pipe_stall = (state_q != IEE_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // One-instruction guard after return or set-enable; armed in the last return
  // cycle so that a boundary in the very first cycle back is refused as well
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_one_q <= 1'b0;
    end
    else
    begin
      if ((state_q == IEE_RETURN && cnt_q == 3'(RETURN_CYCLES - 1))
          || (set_global_irq_enable_instr && instr_boundary))
      begin
        hold_one_q <= 1'b1;
      end
      else if (instr_boundary && state_q == IEE_RUN)
      begin
        hold_one_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register: only the enable bit is touched by hardware
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_flag_register_q <= STATUS_RESET;
    end
    else
    begin
      if (apb_wr && paddr == ADDR_STATUS)
      begin
        status_flag_register_q <= pwdata[7:0];
      end
      if (clear_global_irq_enable_instr)
      begin
        status_flag_register_q[GIE_BIT] <= 1'b0;
      end
      else if (set_global_irq_enable_instr)
      begin
        status_flag_register_q[GIE_BIT] <= 1'b1;
      end
      if (take)
      begin
        status_flag_register_q[GIE_BIT] <= 1'b0;
      end
      else if (state_q == IEE_RETURN && cnt_q == 3'(RETURN_CYCLES - 1))
      begin
        status_flag_register_q[GIE_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-source flag latch; a new event wins over a clear in the same cycle
  assign src_ack = take ? (NUM_SRC'(1) << winner) : '0;

  for (genvar g = 0; g < NUM_SRC; g++)
  begin : g_flag
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        flag_q[g] <= 1'b0;
      end
      else if (src_event[g])
      begin
        flag_q[g] <= 1'b1;
      end
      else if ((take && winner == g) || (apb_wr && paddr == ADDR_FLAG && pwdata[g]))
      begin
        flag_q[g] <= 1'b0;
      end
    end
  end

  // Enable and type registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q  <= '0;
      levtype_q <= '0;
    end
    else if (apb_wr && paddr == ADDR_ENABLE)
    begin
      enable_q <= pwdata[NUM_SRC-1:0];
    end
    else if (apb_wr && paddr == ADDR_LEVTYPE)
    begin
      levtype_q <= pwdata[NUM_SRC-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter, stack pointer and stack port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_q     <= PC_WIDTH'(RESET_VECTOR);
      sp_q     <= SP_RESET;
      ret_pc_q <= '0;
    end
    else
    begin
      if (apb_wr && paddr == ADDR_SP)
      begin
        sp_q <= pwdata[15:0];
      end
      if (apb_wr && paddr == ADDR_PC)
      begin
        pc_q <= pwdata[PC_WIDTH-1:0];
      end
      else if (state_q == IEE_RUN && instr_boundary && !take && !ret_instr)
      begin
        pc_q <= pc_q + (instr_two_word ? PC_WIDTH'(2) : PC_WIDTH'(1));
      end
      if (state_q == IEE_ENTRY && cnt_q == 3'd0)
      begin
        sp_q <= sp_q - 16'(PC_BYTES);
      end
      if (state_q == IEE_ENTRY && cnt_q == 3'(ENTRY_CYCLES - 1))
      begin
        // One-word slot per vector holds the short jump the pipeline then runs
        pc_q <= PC_WIDTH'(sel_q) + PC_WIDTH'(1);
      end
      if (state_q == IEE_RETURN && cnt_q == 3'd0)
      begin
        sp_q <= sp_q + 16'(PC_BYTES);
      end
      if (state_q == IEE_RETURN && cnt_q == 3'd1)
      begin
        ret_pc_q <= PC_WIDTH'({stack_rdata, 8'h00});
      end
      if (state_q == IEE_RETURN && cnt_q == 3'd2)
      begin
        pc_q <= {ret_pc_q[PC_WIDTH-1:8], stack_rdata};
      end
    end
  end

  // Entry writes low then high byte; return reads high then low byte
  always_comb
  begin
    stack_we    = 1'b0;
    stack_addr  = sp_q;
    stack_wdata = 8'h00;
    if (state_q == IEE_ENTRY && cnt_q == 3'd0)
    begin
      stack_we    = 1'b1;
      stack_addr  = sp_q;
      stack_wdata = pc_q[7:0];
    end
    else if (state_q == IEE_ENTRY && cnt_q == 3'd1)
    begin
      stack_we    = 1'b1;
      stack_addr  = sp_q + 16'h0001;
      stack_wdata = 8'(pc_q >> 8);
    end
    else if (state_q == IEE_RETURN && cnt_q == 3'd1)
    begin
      stack_addr = sp_q - 16'h0001;
    end
  end
  assign program_counter = pc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses answer with an error
  always_comb
  begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      ADDR_STATUS:  prdata = 32'(status_flag_register_q);
      ADDR_ENABLE:  prdata = 32'(enable_q);
      ADDR_FLAG:    prdata = 32'(flag_q);
      ADDR_LEVTYPE: prdata = 32'(levtype_q);
      ADDR_SP:      prdata = 32'(sp_q);
      ADDR_PC:      prdata = 32'(pc_q);
      ADDR_STATE:   prdata = 32'(state_q);
      default:      pslverr = psel && penable;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_ack_clears_gie;
    @(posedge pclk) disable iff (!presetn)
    take |=> !status_flag_register_q[GIE_BIT];
  endproperty
  a_ack_clears_gie: assert property (p_ack_clears_gie) else $error("enable not cleared");

  property p_no_take_on_clear;
    @(posedge pclk) disable iff (!presetn)
    clear_global_irq_enable_instr |-> src_ack == '0;
  endproperty
  a_no_take_on_clear: assert property (p_no_take_on_clear) else $error("taken on clear");

  property p_entry_len;
    @(posedge pclk) disable iff (!presetn)
    (take && !core_sleeping) |=> (state_q == IEE_ENTRY) [*4] ##1 state_q == IEE_RUN;
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry length wrong");

  property p_wake_len;
    @(posedge pclk) disable iff (!presetn)
    (take && core_sleeping) |=> (state_q == IEE_WAKE) [*4] ##1 state_q == IEE_ENTRY;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake length wrong");

  property p_ret_sets_gie;
    @(posedge pclk) disable iff (!presetn)
    ($rose(state_q == IEE_RETURN)) |-> ##4 status_flag_register_q[GIE_BIT];
  endproperty
  a_ret_sets_gie: assert property (p_ret_sets_gie) else $error("return left enable clear");

  property p_sp_push;
    @(posedge pclk) disable iff (!presetn)
    (state_q == IEE_ENTRY && cnt_q == 3'd0 && !apb_wr) |=> sp_q == $past(sp_q) - 16'h0002;
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("push not by two");

  property p_ack_onehot;
    @(posedge pclk) disable iff (!presetn)
    (src_ack != '0) |-> $onehot0(src_ack) && global_irq_enable && instr_boundary;
  endproperty
  a_ack_onehot: assert property (p_ack_onehot) else $error("bad acknowledge");

  property p_enable_gate;
    @(posedge pclk) disable iff (!presetn)
    (src_ack != '0) |-> (src_ack & enable_q) == src_ack;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("disabled source taken");
endmodule : iee_core
`default_nettype wire

//--- sim/iee_stack_model.sv
// Byte-wide data memory that holds the return-address stack
`timescale 1ns/1ps
`default_nettype none
module iee_stack_model (
  // Clock
  input  wire logic        pclk,
  // Stack port of the sequencer
  input  wire logic        stack_we,
  input  wire logic [15:0] stack_addr,
  input  wire logic [7:0]  stack_wdata,
  output logic      [7:0]  stack_rdata
);
  logic [7:0] mem_q [0:1023];
  ////////////////////////////////////////////////////////////////////////////////
  // Write on the edge; unwritten bytes read unknown so a bad pop shows
  always_ff @(posedge pclk)
  begin
    if (stack_we)
    begin
      mem_q[stack_addr[9:0]] <= stack_wdata;
    end
  end
  // Read data in the same cycle, as the sequencer expects
  assign stack_rdata = mem_q[stack_addr[9:0]];
endmodule : iee_stack_model
`default_nettype wire

//--- sim/tb_cpu_interrupt_entry_exit.sv
// Self-checking bench of the interrupt entry and exit sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_interrupt_entry_exit import iee_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, src_event, src_level, src_ack, stack_wdata, stack_rdata;
  logic [31:0] pwdata, prdata;
  logic        instr_boundary, instr_two_word, ret_instr, clr_i, set_i, core_sleeping;
  logic        pipe_stall, stack_we, global_irq_enable;
  logic [11:0] program_counter;
  logic [15:0] stack_addr;
  int          fail_count = 0;
  int          cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Design and the stack memory beside it
  iee_core iee_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .src_level(src_level), .src_ack(src_ack),
    .instr_boundary(instr_boundary), .instr_two_word(instr_two_word),
    .ret_instr(ret_instr), .clear_global_irq_enable_instr(clr_i),
    .set_global_irq_enable_instr(set_i), .core_sleeping(core_sleeping),
    .pipe_stall(pipe_stall), .program_counter(program_counter), .stack_we(stack_we),
    .stack_addr(stack_addr), .stack_wdata(stack_wdata), .stack_rdata(stack_rdata),
    .global_irq_enable(global_irq_enable));
  iee_stack_model iee_stack_model_i (.pclk(pclk), .stack_we(stack_we),
    .stack_addr(stack_addr), .stack_wdata(stack_wdata), .stack_rdata(stack_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task finish_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // One APB transfer; held until pready is seen high at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rdchk
  task ev(input logic [7:0] m);
    @(posedge pclk);
    src_event <= m;
    @(posedge pclk);
    src_event <= 8'h00;
  endtask : ev
  // Boundary cycle with optional decoder pulses; acknowledge judged mid-cycle
  task bnd(input logic [7:0] exp, input logic r, input logic c, input logic s);
    @(posedge pclk);
    instr_boundary <= 1'b1;
    ret_instr      <= r;
    clr_i          <= c;
    set_i          <= s;
    #1 chk(src_ack, exp);
    @(posedge pclk);
    instr_boundary <= 1'b0;
    ret_instr      <= 1'b0;
    clr_i          <= 1'b0;
    set_i          <= 1'b0;
  endtask : bnd
  // Length of the stall that follows the last boundary
  task stall(input int exp);
    int n;
    n = 0;
    #1;
    while (pipe_stall === 1'b1 && n < 20)
    begin
      @(posedge pclk);
      #1 n++;
    end
    chk(32'(n), 32'(exp));
  endtask : stall
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset();
    logic [31:0] r;
    logic        e;
    rdchk(ADDR_STATUS, 32'h0);
    rdchk(ADDR_SP, 32'h0000009F);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk(32'(e), 32'h1);
  endtask : t_reset
  task t_entry();
    wr(ADDR_ENABLE, 32'hFF);
    wr(ADDR_PC, 32'h2A5);
    wr(ADDR_STATUS, 32'h80);
    #1 chk(32'(global_irq_enable), 32'h1);
    rdchk(ADDR_PC, 32'h2A5);
    ev(8'h04);
    rdchk(ADDR_FLAG, 32'h04);
    bnd(8'h04, 1'b0, 1'b0, 1'b0);
    stall(4);
    chk(32'(global_irq_enable), 32'h0);
    chk(32'(program_counter), 32'h3);
    rdchk(ADDR_PC, 32'h3);
    rdchk(ADDR_SP, 32'h0000009D);
    rdchk(ADDR_FLAG, 32'h0);
  endtask : t_entry
  task t_return();
    ev(8'h12);
    rdchk(ADDR_FLAG, 32'h12);
    bnd(8'h00, 1'b1, 1'b0, 1'b0);
    stall(4);
    chk(32'(global_irq_enable), 32'h1);
    rdchk(ADDR_SP, 32'h0000009F);
    rdchk(ADDR_PC, 32'h2A5);
    instr_two_word <= 1'b1;
    bnd(8'h00, 1'b0, 1'b0, 1'b0);
    instr_two_word <= 1'b0;
    rdchk(ADDR_PC, 32'h2A7);
    bnd(8'h02, 1'b0, 1'b0, 1'b0);
    stall(4);
  endtask : t_return
  task t_nest();
    bnd(8'h00, 1'b0, 1'b0, 1'b1);
    bnd(8'h00, 1'b0, 1'b0, 1'b0);
    bnd(8'h10, 1'b0, 1'b0, 1'b0);
    stall(4);
    rdchk(ADDR_SP, 32'h0000009B);
  endtask : t_nest
  task t_clear();
    ev(8'h01);
    wr(ADDR_STATUS, 32'h80);
    bnd(8'h00, 1'b0, 1'b1, 1'b0);
    #1 chk(32'(global_irq_enable), 32'h0);
    wr(ADDR_FLAG, 32'h00);
    rdchk(ADDR_FLAG, 32'h01);
    wr(ADDR_FLAG, 32'h01);
    rdchk(ADDR_FLAG, 32'h00);
  endtask : t_clear
  task t_level();
    wr(ADDR_LEVTYPE, 32'h20);
    @(posedge pclk);
    src_level <= 8'h20;
    repeat (3) @(posedge pclk);
    src_level <= 8'h00;
    wr(ADDR_STATUS, 32'h80);
    bnd(8'h00, 1'b0, 1'b0, 1'b0);
    src_level <= 8'h20;
    bnd(8'h20, 1'b0, 1'b0, 1'b0);
    src_level <= 8'h00;
    stall(4);
  endtask : t_level
  task t_sleep();
    wr(ADDR_STATUS, 32'h83);
    core_sleeping <= 1'b1;
    ev(8'h40);
    bnd(8'h40, 1'b0, 1'b0, 1'b0);
    stall(8);
    @(posedge pclk);
    core_sleeping <= 1'b0;
    rdchk(ADDR_STATUS, 32'h03);
  endtask : t_sleep
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reset, main sequence and watchdog
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  initial
  begin
    {presetn, psel, penable, pwrite, instr_boundary, instr_two_word} = '0;
    {ret_instr, clr_i, set_i, core_sleeping} = '0;
    {paddr, src_event, src_level} = '0;
    pwdata = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_entry();
    t_return();
    t_nest();
    t_clear();
    t_level();
    t_sleep();
    finish_test();
  end
  // Whole run is under two hundred cycles; this bound only catches a hang
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule : tb_cpu_interrupt_entry_exit
`default_nettype wire
